//--- rsd_regs.svh
// Purpose: Register offsets, field positions, reset values and timing counts
// Assumes: 32-bit AHB-Lite, one aligned word per register
// Notes: Offsets are byte addresses within the block window
`ifndef RSD_REGS_SVH
`define RSD_REGS_SVH
`define RSD_OFS_FLAGS 8'h00
`define RSD_OFS_MULT 8'h04
`define RSD_OFS_CNT_LO 8'h08
`define RSD_OFS_CNT_HI 8'h0C
`define RSD_OFS_ADDR_LO 8'h10
`define RSD_OFS_UNIT 8'h14
`define RSD_OFS_MIN 8'h18
`define RSD_OFS_CFG 8'h1C
`define RSD_OFS_CMD 8'h20
`define RSD_OFS_STATUS 8'h24
`define RSD_OFS_ERR_REG 8'h28
`define RSD_OFS_ERR_LOG 8'h2C
`define RSD_OFS_ERR_ADDR 8'h30
`define RSD_OFS_ERR_CNT 8'h34
`define RSD_OFS_LIMIT 8'h38
`define RSD_BIT_URG 7
`define RSD_BIT_RC 6
`define RSD_BIT_NS 5
`define RSD_BIT_RESUME 4
`define RSD_BIT_CFG_VALID 8
`define RSD_BIT_PEND 9
`define RSD_ST_BSY 7
`define RSD_ST_SE 5
`define RSD_ST_ERR 0
`define RSD_EL_COMPLETION_TIMEOUT_BIT 0
`define RSD_FULL_COUNT 17'h10000
`define RSD_UNIT_RST 16'h0001
`define RSD_MIN_LIMIT_RST 24'h000001
`define RSD_CLK_PERIOD_NS 10
`define RSD_US_NS 1000
`define RSD_CYC_PER_US (`RSD_US_NS / `RSD_CLK_PERIOD_NS)
`endif

//--- rsd_pkg.sv
// Purpose: Types shared by the stream read decoder modules
// Assumes: rsd_regs.svh holds all numbers
// Notes: State of each decoder module is one packed struct
package rsd_pkg;
    typedef enum logic [1:0] {rsd_idle, rsd_run, rsd_end} rsd_state_t;

    typedef struct packed {
        logic running;
        logic [6:0] pre;
        logic [23:0] us_cnt;
        logic [23:0] limit;
        logic on;
        logic expired;
    } rsd_tmr_st_t;

    typedef struct packed {
        rsd_state_t state;
        logic [7:0] flags;
        logic [7:0] mult;
        logic [7:0] cnt_lo;
        logic [7:0] cnt_hi;
        logic [7:0] addr_lo;
        logic [15:0] unit;
        logic [23:0] min_lim;
        logic [7:0] run;
        logic [7:0] run_addr;
        logic [9:0] entry;
        logic [16:0] total;
        logic [16:0] done_cnt;
        logic err_seen;
        logic run_open;
        logic [16:0] first_idx;
        logic [16:0] err_run;
        logic [7:0] err_log;
        logic [7:0] err_reg;
        logic se;
        logic err;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] hrdata;
        logic start_pulse;
        logic abort_pulse;
        logic end_pulse;
        logic resume_rec;
    } rsd_top_st_t;
endpackage

//--- rsd_if.sv
// Purpose: Link between the command logic and the time limit unit
// Assumes: One clock domain
// Notes: ctrl side starts and stops, tmr side reports expiry
`timescale 1ns/1ps
interface rsd_if;
    logic start;
    logic stop;
    logic [7:0] mult;
    logic [15:0] unit;
    logic [7:0] dflt;
    logic dflt_ok;
    logic [23:0] min_lim;
    logic expired;
    logic on;
    logic [23:0] limit_us;
    modport ctrl (output start, stop, mult, unit, dflt, dflt_ok, min_lim,
                  input expired, on, limit_us);
    modport tmr (input start, stop, mult, unit, dflt, dflt_ok, min_lim,
                 output expired, on, limit_us);
endinterface

//--- rsd_limit_timer.sv
// Purpose: Works out the completion time limit and times the command
// Assumes: hclk at 100 MHz
// Notes: Limit held in microseconds, 24 bits covers 255 x 65535
`timescale 1ns/1ps
`include "rsd_regs.svh"
module rsd_limit_timer
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Command side
    rsd_if.tmr tif
);
    import rsd_pkg::*;

    rsd_tmr_st_t r_reg, r_next;
    logic [7:0] base;
    logic [23:0] req;

    always_comb
    begin
        r_next = r_reg;
        base = (tif.mult != 8'h00) ? tif.mult : tif.dflt;
        req = {16'h0000, base} * {8'h00, tif.unit};
        if (tif.start)
        begin
            r_next.running = 1'b1;
            r_next.pre = 7'h00;
            r_next.us_cnt = 24'h000000;
            r_next.expired = 1'b0;
            // Zero multiplier falls back to the stream default
            r_next.on = (tif.mult != 8'h00) || (tif.dflt_ok && tif.dflt != 8'h00);
            r_next.limit = (req < tif.min_lim) ? tif.min_lim : req;
        end
        else if (tif.stop)
        begin
            r_next.running = 1'b0;
        end
        else if (r_reg.running)
        begin
            if (r_reg.pre == 7'(`RSD_CYC_PER_US - 1))
            begin
                r_next.pre = 7'h00;
                if (r_reg.us_cnt != 24'hFFFFFF)
                    r_next.us_cnt = r_reg.us_cnt + 24'h000001;
            end
            else
                r_next.pre = r_reg.pre + 7'h01;
            if (r_reg.on && r_reg.us_cnt >= r_reg.limit)
                r_next.expired = 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            r_reg <= '0;
        else
            r_reg <= r_next;
    end

    assign tif.expired = r_reg.expired;
    assign tif.on = r_reg.on;
    assign tif.limit_us = r_reg.limit;
endmodule // rsd_limit_timer

//--- rsd_stream_mem.sv
// Purpose: Per-stream memory of default limit and pending error
// Assumes: One write port, one read port
// Notes: Read data come from a register, one cycle after the address
`timescale 1ns/1ps
module rsd_stream_mem
#(
    parameter int DEPTH = 8,
    parameter int WIDTH = 10,
    parameter int AW = 3
)
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Ports
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [WIDTH-1:0] rdata
);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [WIDTH-1:0] rd;
    } rsd_mem_st_t;

    rsd_mem_st_t r_reg, r_next;

    always_comb
    begin
        r_next = r_reg;
        r_next.rd = r_reg.mem[raddr];
        if (we)
            r_next.mem[waddr] = wdata;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            r_reg <= '0;
        else
            r_reg <= r_next;
    end

    assign rdata = r_reg.rd;
endmodule // rsd_stream_mem

//--- rsd_top.sv
// Purpose: Decodes and runs the parameters of a streaming read command
// Assumes: AHB-Lite slave, zero wait states; sector engine reports per sector
// Notes: Upper address bytes are handled outside this block
//
// What this block does
// - Urgent flag asks for fastest finish, still within the time limit.
// - Continuous read never aborts on media or transfer errors.
// - Continuous read with errors: full transfer, stream error, log entry.
// - Continuous read, limit elapsed: halt, stream error, timeout logged.
// - Always try to move the full count within the limit. Without continuous read, the block aborts on the first sector error.
// - Error resume starts at last error address; recovery may continue. The block starts at the written low address byte instead.
// - Low three flag bits select the stream.
// - Limit in microseconds is multiplier times time unit.
// - Zero multiplier uses the stream's configured default.
// - Zero or missing default means no time limit.
// - Limit runs from command write to final completion.
// - A limit below the minimum is raised to it.
// - Count is high byte over low byte.
// - Count of zero means 65,536 sectors.
// - Errors under continuous read set stream error; bits go to log.
// - Stream error reports first erroneous sector address.
// - Stream error reports count of consecutive suspect sectors.
//
// Design decisions made here: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
`include "rsd_regs.svh"
module rsd_top
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Command to sector engine
    output logic start_pulse,
    output logic [16:0] xfer_count,
    output logic [7:0] xfer_addr_low,
    output logic [2:0] stream_selector,
    output logic urgent_flag,
    output logic continuous_read_flag,
    output logic non_sequential_flag,
    output logic error_resume_flag,
    output logic resume_recovery,
    output logic abort_pulse,
    output logic done_pulse,
    // Sector progress from engine
    input wire logic sec_done,
    input wire logic sec_err,
    input wire logic [3:0] sec_err_type
);
    import rsd_pkg::*;

    rsd_top_st_t r_reg, r_next;
    rsd_if tif ();
    logic [9:0] mem_rdata;
    logic mem_we;
    logic [2:0] mem_waddr;
    logic [9:0] mem_wdata;
    logic cmd_hit;
    logic cfg_hit;

    // --------------------
    // Helpers
    // --------------------
    function automatic logic [16:0] sector_total(input logic [7:0] hi, input logic [7:0] lo);
        return ({hi, lo} == 16'h0000) ? `RSD_FULL_COUNT : {1'b0, hi, lo};
    endfunction

    // Engine error type {crc, unc, idnf, abrt} to register bit layout
    function automatic logic [7:0] err_bits(input logic [3:0] t);
        return {t[3], t[2], 1'b0, t[1], 1'b0, t[0], 2'b00};
    endfunction

    function automatic logic [31:0] read_word(input rsd_top_st_t s, input logic [7:0] a,
                                              input logic on, input logic [23:0] lim);
        logic [31:0] w;
        w = 32'h00000000;
        case (a)
            `RSD_OFS_UNIT: w = {16'h0000, s.unit};
            `RSD_OFS_MIN: w = {8'h00, s.min_lim};
            `RSD_OFS_STATUS:
            begin
                w[`RSD_ST_BSY] = (s.state != rsd_idle);
                w[`RSD_ST_SE] = s.se;
                w[`RSD_ST_ERR] = s.err;
            end
            `RSD_OFS_ERR_REG: w = {24'h000000, s.err_reg};
            `RSD_OFS_ERR_LOG: w = {24'h000000, s.err_log};
            `RSD_OFS_ERR_ADDR: w = {7'h00, s.first_idx, s.run_addr + s.first_idx[7:0]};
            `RSD_OFS_ERR_CNT: w = {15'h0000, s.err_run};
            `RSD_OFS_LIMIT: w = {on, 7'h00, lim};
            default: w = 32'h00000000;
        endcase
        return w;
    endfunction

    // --------------------
    // Next state
    // --------------------
    assign cmd_hit = r_reg.wr_pend && r_reg.wr_addr == `RSD_OFS_CMD && r_reg.state == rsd_idle;
    assign cfg_hit = r_reg.wr_pend && r_reg.wr_addr == `RSD_OFS_CFG && r_reg.state == rsd_idle;

    always_comb
    begin
        r_next = r_reg;
        r_next.start_pulse = 1'b0;
        r_next.abort_pulse = 1'b0;
        r_next.end_pulse = 1'b0;
        r_next.wr_pend = 1'b0;

        // Address phase; read data registered for the data phase
        if (hsel && htrans[1] && hready)
        begin
            r_next.wr_pend = hwrite;
            r_next.wr_addr = haddr[7:0];
            if (!hwrite)
                r_next.hrdata = read_word(r_reg, haddr[7:0], tif.on, tif.limit_us);
        end

        // Data phase of a write; parameter registers are shadows latched at start
        if (r_reg.wr_pend)
        begin
            case (r_reg.wr_addr)
                `RSD_OFS_FLAGS: r_next.flags = hwdata[7:0];
                `RSD_OFS_MULT: r_next.mult = hwdata[7:0];
                `RSD_OFS_CNT_LO: r_next.cnt_lo = hwdata[7:0];
                `RSD_OFS_CNT_HI: r_next.cnt_hi = hwdata[7:0];
                `RSD_OFS_ADDR_LO: r_next.addr_lo = hwdata[7:0];
                `RSD_OFS_UNIT: r_next.unit = hwdata[15:0];
                `RSD_OFS_MIN: r_next.min_lim = hwdata[23:0];
                default: ;
            endcase
        end

        case (r_reg.state)
            rsd_idle:
            begin
                if (cmd_hit)
                begin
                    r_next.run = r_reg.flags;
                    r_next.run_addr = r_reg.addr_lo;
                    r_next.total = sector_total(r_reg.cnt_hi, r_reg.cnt_lo);
                    r_next.entry = mem_rdata;
                    // Recovery only resumes when this stream has an error on record
                    r_next.resume_rec = r_reg.flags[`RSD_BIT_RESUME] && mem_rdata[`RSD_BIT_PEND];
                    r_next.done_cnt = 17'h00000;
                    r_next.err_seen = 1'b0;
                    r_next.run_open = 1'b0;
                    r_next.first_idx = 17'h00000;
                    r_next.err_run = 17'h00000;
                    r_next.err_log = 8'h00;
                    r_next.err_reg = 8'h00;
                    r_next.se = 1'b0;
                    r_next.err = 1'b0;
                    r_next.start_pulse = 1'b1;
                    r_next.state = rsd_run;
                end
            end
            rsd_run:
            begin
                if (sec_done)
                begin
                    r_next.done_cnt = r_reg.done_cnt + 17'h00001;
                    if (sec_err && r_reg.run[`RSD_BIT_RC])
                    begin
                        // Keep going; only the log and stream error record it
                        r_next.se = 1'b1;
                        r_next.err_log = r_reg.err_log | err_bits(sec_err_type);
                        if (!r_reg.err_seen)
                        begin
                            r_next.err_seen = 1'b1;
                            r_next.run_open = 1'b1;
                            r_next.first_idx = r_reg.done_cnt;
                            r_next.err_run = 17'h00001;
                        end
                        else if (r_reg.run_open)
                            r_next.err_run = r_reg.err_run + 17'h00001;
                    end
                    else if (sec_err)
                    begin
                        r_next.err = 1'b1;
                        r_next.err_reg = err_bits(sec_err_type);
                        r_next.err_seen = 1'b1;
                        r_next.first_idx = r_reg.done_cnt;
                        r_next.err_run = 17'h00001;
                        r_next.abort_pulse = 1'b1;
                        r_next.state = rsd_end;
                    end
                    else
                        r_next.run_open = 1'b0;
                    if (r_next.done_cnt == r_reg.total)
                        r_next.state = rsd_end;
                end
                // Limit expiry halts the command even mid-transfer
                if (tif.expired && r_next.state == rsd_run)
                begin
                    if (r_reg.run[`RSD_BIT_RC])
                    begin
                        r_next.se = 1'b1;
                        r_next.err_log[`RSD_EL_COMPLETION_TIMEOUT_BIT] = 1'b1;
                    end
                    else
                    begin
                        r_next.err = 1'b1;
                        r_next.err_reg[`RSD_EL_COMPLETION_TIMEOUT_BIT] = 1'b1;
                    end
                    r_next.abort_pulse = 1'b1;
                    r_next.state = rsd_end;
                end
            end
            rsd_end:
            begin
                r_next.end_pulse = 1'b1;
                r_next.resume_rec = 1'b0;
                r_next.state = rsd_idle;
            end
            default: r_next.state = rsd_idle;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            r_reg <= '0;
            r_reg.state <= rsd_idle;
            r_reg.unit <= `RSD_UNIT_RST;
            r_reg.min_lim <= `RSD_MIN_LIMIT_RST;
        end
        else
            r_reg <= r_next;
    end

    // --------------------
    // Stream memory: config when idle, error record at end
    // --------------------
    always_comb
    begin
        mem_we = 1'b0;
        mem_waddr = hwdata[12:10];
        mem_wdata = {1'b0, hwdata[`RSD_BIT_CFG_VALID], hwdata[7:0]};
        if (r_reg.state == rsd_end)
        begin
            mem_we = 1'b1;
            mem_waddr = r_reg.run[2:0];
            // Pending error kept for a later resume; a clean run clears it
            mem_wdata = {r_reg.se | r_reg.err, r_reg.entry[8:0]};
        end
        else if (cfg_hit)
        begin
            mem_we = 1'b1;
            // Reconfiguring a stream drops any pending error
            mem_wdata[`RSD_BIT_PEND] = 1'b0;
        end
    end

    rsd_stream_mem #(.DEPTH(8), .WIDTH(10), .AW(3)) u_mem
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .we(mem_we),
        .waddr(mem_waddr),
        .wdata(mem_wdata),
        .raddr(r_next.flags[2:0]),
        .rdata(mem_rdata)
    );

    // --------------------
    // Time limit
    // --------------------
    assign tif.start = cmd_hit;
    assign tif.stop = (r_reg.state == rsd_end);
    assign tif.mult = r_reg.mult;
    assign tif.unit = r_reg.unit;
    assign tif.dflt = mem_rdata[7:0];
    assign tif.dflt_ok = mem_rdata[`RSD_BIT_CFG_VALID];
    assign tif.min_lim = r_reg.min_lim;

    rsd_limit_timer u_tmr
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .tif(tif.tmr)
    );

    // --------------------
    // Outputs
    // --------------------
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = r_reg.hrdata;
    assign start_pulse = r_reg.start_pulse;
    assign xfer_count = r_reg.total;
    assign xfer_addr_low = r_reg.run_addr;
    assign stream_selector = r_reg.run[2:0];
    assign urgent_flag = r_reg.run[`RSD_BIT_URG];
    assign continuous_read_flag = r_reg.run[`RSD_BIT_RC];
    assign non_sequential_flag = r_reg.run[`RSD_BIT_NS];
    assign error_resume_flag = r_reg.run[`RSD_BIT_RESUME];
    assign resume_recovery = r_reg.resume_rec;
    assign abort_pulse = r_reg.abort_pulse;
    assign done_pulse = r_reg.end_pulse;
endmodule // rsd_top

//--- rsd_top_monitor.sv
// Purpose: Timing checks on the decoder top ports
// Assumes: One clock, reset active low
// Notes: Bound to every rsd_top instance
`timescale 1ns/1ps
module rsd_top_monitor
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    // Engine side
    input wire logic start_pulse,
    input wire logic [16:0] xfer_count,
    input wire logic [2:0] stream_selector,
    input wire logic urgent_flag,
    input wire logic continuous_read_flag,
    input wire logic error_resume_flag,
    input wire logic resume_recovery,
    input wire logic abort_pulse,
    input wire logic done_pulse,
    input wire logic sec_done,
    input wire logic sec_err
);
    logic busy_reg;
    logic cmd_dp_reg;
    logic [16:0] sec_cnt_reg;
    // --------------------
    // Helper state
    // --------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            busy_reg <= 1'b0;
            cmd_dp_reg <= 1'b0;
            sec_cnt_reg <= 17'h0;
        end
        else
        begin
            busy_reg <= start_pulse | (busy_reg & ~done_pulse);
            cmd_dp_reg <= hsel & htrans[1] & hready & hwrite & (haddr[7:0] == 8'h20);
            sec_cnt_reg <= start_pulse ? 17'h0 : sec_cnt_reg + 17'(busy_reg & sec_done);
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // --------------------
    // Assertions
    // --------------------
    a_start_after_cmd: assert property (start_pulse |-> $past(cmd_dp_reg))
        else $error("start without command write");
    a_count_range: assert property (start_pulse |-> xfer_count != 17'h0
        && xfer_count <= 17'h10000) else $error("sector count out of range");
    a_flags_hold: assert property (!start_pulse |-> $stable({urgent_flag,
        continuous_read_flag, error_resume_flag, stream_selector}))
        else $error("flags moved without a command");
    a_rc_no_abort: assert property (busy_reg && continuous_read_flag && sec_done
        && sec_err |=> !abort_pulse [*2]) else $error("continuous read aborted");
    a_err_aborts: assert property (busy_reg && !continuous_read_flag && sec_done
        && sec_err |-> ##[1:2] abort_pulse) else $error("error did not abort");
    a_abort_ends: assert property (abort_pulse |=> done_pulse)
        else $error("abort without completion");
    a_full_count: assert property (done_pulse && !$past(abort_pulse)
        |-> sec_cnt_reg == xfer_count) else $error("completed short of count");
    a_resume_flag: assert property (resume_recovery |-> error_resume_flag)
        else $error("recovery without resume flag");
    a_done_single: assert property (done_pulse |=> !done_pulse)
        else $error("completion pulse too long");
endmodule // rsd_top_monitor

bind rsd_top rsd_top_monitor i_mon (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .start_pulse(start_pulse), .xfer_count(xfer_count),
    .stream_selector(stream_selector), .urgent_flag(urgent_flag),
    .continuous_read_flag(continuous_read_flag), .error_resume_flag(error_resume_flag),
    .resume_recovery(resume_recovery), .abort_pulse(abort_pulse),
    .done_pulse(done_pulse), .sec_done(sec_done), .sec_err(sec_err));

//--- rsd_host_model.sv
// Purpose: Host bus master writing the command block registers
// Assumes: Single word transfers, slave always answers OKAY
// Notes: Released lines show inverted data so stale values never match
`timescale 1ns/1ps
module rsd_host_model
(
    // Clock
    input wire logic hclk,
    // Bus master
    output logic hsel = 1'b0,
    output logic [31:0] haddr = 32'h0,
    output logic [1:0] htrans = 2'b00,
    output logic hwrite = 1'b0,
    output logic [2:0] hsize = 3'b010,
    output logic [31:0] hwdata = 32'h0,
    input wire logic hready,
    input wire logic [31:0] hrdata
);
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
        hsel <= 1'b0;
        haddr <= ~haddr;
        hwdata <= ~d;
    endtask
endmodule // rsd_host_model

//--- rsd_top_bench.sv
// Purpose: Self-checking bench for the stream read decoder
// Assumes: Time unit of 1 us per step, 100 cycles per us
// Notes: Ordinary commands run from a table, limit cases by hand
`timescale 1ns/1ps
module rsd_top_bench;
    typedef struct {
        logic [7:0] fl, lo, hi, ad;
        logic e;
        logic [16:0] cnt;
        logic [7:0] st, el, er;
        logic rs;
    } rsd_row_t;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel, hwrite, hreadyout, hresp, start_pulse, abort_pulse, done_pulse;
    logic urgent_flag, continuous_read_flag, non_sequential_flag, error_resume_flag;
    logic resume_recovery;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0] htrans;
    logic [2:0] hsize, stream_selector;
    logic [16:0] xfer_count;
    logic [7:0] xfer_addr_low;
    logic sec_done = 1'b0;
    logic sec_err = 1'b0;
    logic [3:0] sec_err_type = 4'h0;
    int n_fail = 0;
    int total_checks = 0;
    int i;
    time t0;
    rsd_row_t rows [4] = '{
        '{8'h85, 8'h03, 8'h00, 8'hA5, 1'b0, 17'h00003, 8'h00, 8'h00, 8'h00, 1'b0},
        '{8'h46, 8'h02, 8'h01, 8'h3C, 1'b1, 17'h00102, 8'h20, 8'h40, 8'h00, 1'b0},
        '{8'h21, 8'h00, 8'h00, 8'h00, 1'b1, 17'h10000, 8'h01, 8'h00, 8'h80, 1'b0},
        '{8'h11, 8'h01, 8'h00, 8'h7E, 1'b0, 17'h00001, 8'h00, 8'h00, 8'h00, 1'b1}};

    rsd_host_model i_host (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata));
    rsd_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .start_pulse(start_pulse), .xfer_count(xfer_count), .xfer_addr_low(xfer_addr_low),
        .stream_selector(stream_selector), .urgent_flag(urgent_flag),
        .continuous_read_flag(continuous_read_flag),
        .non_sequential_flag(non_sequential_flag), .error_resume_flag(error_resume_flag),
        .resume_recovery(resume_recovery), .abort_pulse(abort_pulse),
        .done_pulse(done_pulse), .sec_done(sec_done), .sec_err(sec_err),
        .sec_err_type(sec_err_type));

    // --------------------
    // Tasks
    // --------------------
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_host.xfer(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        i_host.xfer(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask
    task automatic go();
        wr(8'h20, 32'h0);
        @(posedge hclk);
        chk(32'(start_pulse), 32'h1);
        chk(32'(hresp), 32'h0);
    endtask
    // Feeds n sectors, first one errored if asked, then waits for completion
    task automatic feed(input int n, input logic e, input logic [3:0] t);
        int k;
        for (k = 0; k < n; k++)
        begin
            sec_done <= 1'b1;
            sec_err <= e && (k == 0);
            sec_err_type <= t;
            @(posedge hclk);
            if (abort_pulse === 1'b1)
                break;
        end
        sec_done <= 1'b0;
        sec_err <= 1'b0;
        for (k = 0; k < 2000 && done_pulse !== 1'b1; k++)
            @(posedge hclk);
        chk(32'(done_pulse), 32'h1);
    endtask
    task automatic test_done();
        if (n_fail == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // --------------------
    // Sequence
    // --------------------
    initial
    begin
        forever #5 hclk = ~hclk;
    end
    initial
    begin
        #300000;
        n_fail++;
        test_done();
    end
    initial
    begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        rd(8'h14, 32'h1);
        rd(8'h18, 32'h1);
        rd(8'h3C, 32'h0);
        rd(8'h00, 32'h0);
        for (i = 0; i < 4; i++)
        begin
            wr(8'h00, {24'h0, rows[i].fl});
            wr(8'h04, 32'h0);
            wr(8'h08, {24'h0, rows[i].lo});
            wr(8'h0C, {24'h0, rows[i].hi});
            wr(8'h10, {24'h0, rows[i].ad});
            go();
            chk(32'(xfer_count), 32'(rows[i].cnt));
            chk(32'(xfer_addr_low), {24'h0, rows[i].ad});
            chk({24'h0, urgent_flag, continuous_read_flag, non_sequential_flag,
                error_resume_flag, 1'b0, stream_selector}, {24'h0, rows[i].fl & 8'hF7});
            chk(32'(resume_recovery), 32'(rows[i].rs));
            feed(int'(rows[i].cnt), rows[i].e, rows[i].fl[6] ? 4'h4 : 4'h8);
            rd(8'h24, {24'h0, rows[i].st});
            rd(8'h2C, {24'h0, rows[i].el});
            rd(8'h28, {24'h0, rows[i].er});
            if (rows[i].e & rows[i].fl[6])
            begin
                rd(8'h30, {24'h0, rows[i].ad});
                rd(8'h34, 32'h1);
            end
        end
        // Limit expiry under continuous read, plus a refused command while busy
        wr(8'h04, 32'h3);
        wr(8'h00, 32'h40);
        wr(8'h08, 32'h0);
        wr(8'h0C, 32'h1);
        go();
        t0 = $time;
        rd(8'h38, 32'h80000003);
        wr(8'h20, 32'h0);
        @(posedge hclk);
        chk(32'(start_pulse), 32'h0);
        feed(0, 1'b0, 4'h0);
        chk(32'(($time - t0) >= 2980 && ($time - t0) <= 4050), 32'h1);
        rd(8'h24, 32'h20);
        rd(8'h2C, 32'h1);
        // Minimum clamp, expiry without continuous read
        wr(8'h18, 32'h5);
        wr(8'h04, 32'h2);
        wr(8'h00, 32'h0);
        go();
        rd(8'h38, 32'h80000005);
        feed(0, 1'b0, 4'h0);
        rd(8'h24, 32'h1);
        rd(8'h28, 32'h1);
        // Stream default limit, then an unconfigured stream
        wr(8'h18, 32'h1);
        wr(8'h1C, 32'h00000D04);
        wr(8'h04, 32'h0);
        wr(8'h00, 32'h3);
        wr(8'h08, 32'h1);
        wr(8'h0C, 32'h0);
        go();
        rd(8'h38, 32'h80000004);
        feed(1, 1'b0, 4'h0);
        wr(8'h00, 32'h4);
        go();
        i_host.xfer(1'b0, 8'h38, 32'h0, q);
        chk(32'(q[31]), 32'h0);
        feed(1, 1'b0, 4'h0);
        test_done();
    end
endmodule // rsd_top_bench
